// [design/cst_top.v]
// Purpose: Cascade single-wire transceiver with an AXI4-Lite register port.
// Assumes: serial_in_line is asynchronous; aclk runs at 250 MHz.
// Notes:   Cascade clock is aclk divided by the divider register plus one.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
`include "cst_map.vh"

module cst_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  input  wire        serial_in_line,
  output wire        serial_out_line,
  output wire        word_full_irq,
  output wire        cascade_interrupt
);
  // Register kinds returned by the address decoder.
  localparam [3:0] K_CTRL = 4'h0, K_STAT = 4'h1, K_WORD = 4'h2,
                   K_THR  = 4'h3, K_BT   = 4'h4, K_RT   = 4'h5,
                   K_GRP  = 4'h6, K_DIV  = 4'h7, K_DATA = 4'h8,
                   K_NONE = 4'hF;
  // Receive sequencer states, one-hot.
  localparam [2:0] S_IDLE = 3'b001, S_HIGH = 3'b010, S_LOW = 3'b100;

  // Maps a byte address to a register kind; used by reads and writes.
  function [3:0] cst_kind;
    input [7:0] a;
    begin
      if (a[1:0] != 2'b00) begin
        cst_kind = K_NONE;
      end else if (a >= `CST_OFF_DATA) begin
        cst_kind = K_DATA;
      end else begin
        case (a)
          `CST_OFF_CTRL:    cst_kind = K_CTRL;
          `CST_OFF_STAT:    cst_kind = K_STAT;
          `CST_OFF_WORD:    cst_kind = K_WORD;
          `CST_OFF_THRESH:  cst_kind = K_THR;
          `CST_OFF_BITTIME: cst_kind = K_BT;
          `CST_OFF_RSTTIME: cst_kind = K_RT;
          `CST_OFF_GROUP:   cst_kind = K_GRP;
          `CST_OFF_CLKDIV:  cst_kind = K_DIV;
          default:          cst_kind = K_NONE;
        endcase
      end
    end
  endfunction

  // Bus slave state.
  reg        aw_have_r;   // Write address held.
  reg        w_have_r;    // Write data held.
  reg [7:0]  aw_addr_r;   // Held write address.
  reg [7:0]  w_byte_r;    // Held low data byte.
  reg        w_lane_r;    // Low byte lane was enabled.
  reg        bvalid_r;    // Write answer pending.
  reg [1:0]  bresp_r;     // Write answer code.
  reg        rvalid_r;    // Read answer pending.
  reg [1:0]  rresp_r;     // Read answer code.
  reg [31:0] rdata_r;     // Read answer data.

  // Software-visible registers.
  reg        en_r;        // transceiver_enable.
  reg        dir_r;       // direction_select, one selects transmit.
  reg        bypass_r;    // bypass_enable.
  reg        trig_r;      // transmit_trigger.
  reg        rxen_r;      // receive_enable.
  reg        lres_r;      // line_reset_flag.
  reg        wfull_r;     // word_full_flag.
  reg        gfull_r;     // group_full_flag.
  reg        btout_r;     // bit_timeout_flag.
  reg        empty_r;     // transmit_empty_flag.
  reg [3:0]  ien_r;       // Enables for timeout, reset, empty, group.
  reg        wien_r;      // word_full_irq_enable.
  reg [7:0]  thr_r;       // high_count_threshold.
  reg [7:0]  bt_r;        // bit_time_counter reload value.
  reg [7:0]  rt_r;        // reset_time_counter reload value.
  reg [3:0]  grp_r;       // group_count_select.
  reg [7:0]  div_r;       // aclk cycles per cascade clock, minus one.
  reg [7:0]  mem [0:`CST_DATA_BYTES-1]; // data_byte_0 upward.

  // Timing and receive state.
  reg [7:0]  dcnt_r;      // Cascade clock divider.
  reg [3:0]  c16_r;       // Divide-by-16 prescaler.
  reg [7:0]  reset_time_counter_r;      // Live reset-time down-counter.
  reg        fired_r;     // Line reset already reported for this idle.
  reg [2:0]  st_r;        // Receive sequencer state.
  reg [7:0]  hcnt_r;      // High-level tick count.
  reg [7:0]  btim_r;      // Live bit-time down-counter.
  reg [8:0]  bidx_r;      // Bit index within the 24xN group.
  reg [4:0]  wcnt_r;      // Bit index within the current 24-bit word.
  reg        sout_r;      // Registered serial output.
  reg        wirq_r;      // Registered word interrupt.
  reg        cirq_r;      // Registered cascade interrupt.

  wire       in_lvl;
  wire       in_rise;
  wire       in_fall;
  wire       tx_line;
  wire       tx_done;
  wire       tx_busy;
  integer    i;

  // Input synchroniser feeding the decoder and the bypass path.
  cst_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (serial_in_line),
    .level   (in_lvl),
    .rise    (in_rise),
    .fall    (in_fall)
  );

  wire tick   = (dcnt_r >= div_r);   // Never stalls when div shrinks.
  wire tick16 = tick & (c16_r == 4'hF);
  wire rx_on  = en_r & ~dir_r;
  wire tx_on  = en_r & dir_r;
  wire lr_ev  = rx_on & (reset_time_counter_r == 8'h00) & ~fired_r;
  wire [8:0] total = ({5'h00, grp_r} + 9'h001) * `CST_BITS_PER_N;
  wire is_last = (bidx_r == total - 9'h001);
  wire rx_go = rx_on & rxen_r & ~btout_r;
  wire bt_exp = tick & (btim_r <= 8'h01);

  // A pulse decodes to one at threshold plus one or more ticks.
  wire [8:0] hc9 = {1'b0, hcnt_r};
  wire       hi_bit = (hc9 >= {1'b0, thr_r} + 9'h001);

  // Receive events, one-cycle pulses decoded from the sequencer state.
  // Kept combinational so that every clocked process sees one cycle.
  wire seq_run    = rx_go & ~lr_ev;
  wire in_high    = seq_run & (st_r == S_HIGH);
  wire bit_ev     = in_high & in_fall;
  wire bit_val    = hi_bit;
  wire word_ev    = bit_ev & (wcnt_r == `CST_WORD_BITS);
  wire grp_ev     = bit_ev & is_last;
  wire to_ev      = bt_exp & ((in_high & ~in_fall) |
                    (seq_run & (st_r == S_LOW) & ~in_rise));
  wire last_to_ev = to_ev & in_high & is_last;

  // Bus handshakes; one write and one read outstanding at most.
  wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
  wire ar_go = arvalid & ~rvalid_r;
  wire [3:0] wk = cst_kind(aw_addr_r);
  wire [3:0] rk = cst_kind(araddr);
  wire [5:0] widx = aw_addr_r[7:2] - `CST_DATA_BASE_IDX;
  wire [5:0] ridx = araddr[7:2] - `CST_DATA_BASE_IDX;
  wire wr_ok = wr_go & w_lane_r;
  wire trig_wr = wr_ok & (wk == K_CTRL) & w_byte_r[`CST_CTRL_TRIG];

  assign awready = ~aw_have_r & ~bvalid_r;
  assign wready  = ~w_have_r & ~bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign serial_out_line   = sout_r;
  assign word_full_irq     = wirq_r;
  assign cascade_interrupt = cirq_r;

  // Transmit encoder; the first data byte leaves first.
  cst_tx u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .start   (trig_wr & tx_on),
    .thresh  (thr_r),
    .data    ({mem[0], mem[1], mem[2]}),
    .line    (tx_line),
    .busy    (tx_busy),
    .done    (tx_done)
  );

  // Write channel capture and answer; address and data in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CST_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        // Unmapped words answer with a slave error and change nothing.
        bresp_r   <= (wk == K_NONE) ? `CST_RESP_SLVERR : `CST_RESP_OKAY;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel; data are taken on the same edge as the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `CST_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= (rk == K_NONE) ? `CST_RESP_SLVERR : `CST_RESP_OKAY;
      case (rk)
        K_CTRL:  rdata_r <= {27'h000_0000, rxen_r, trig_r, bypass_r,
                             dir_r, en_r};
        K_STAT:  rdata_r <= {24'h00_0000, btout_r, lres_r, empty_r,
                             gfull_r, ien_r};
        K_WORD:  rdata_r <= {27'h000_0000, wfull_r, 3'b000, wien_r};
        K_THR:   rdata_r <= {24'h00_0000, thr_r};
        K_BT:    rdata_r <= {24'h00_0000, bt_r};
        K_RT:    rdata_r <= {24'h00_0000, reset_time_counter_r};
        K_GRP:   rdata_r <= {28'h000_0000, grp_r};
        K_DIV:   rdata_r <= {24'h00_0000, div_r};
        K_DATA:  rdata_r <= {24'h00_0000, mem[ridx]};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Cascade clock tick and its divide-by-16 companion.
  always @(posedge aclk) begin
    if (!aresetn) begin
      dcnt_r <= 8'h00;
      c16_r  <= 4'h0;
    end else begin
      dcnt_r <= tick ? 8'h00 : dcnt_r + 8'h01;
      if (tick) begin
        c16_r <= c16_r + 4'h1;
      end
    end
  end

  // Reset-time counter: reloads on any line edge, counts in rx mode.
  always @(posedge aclk) begin
    if (!aresetn || !rx_on || in_rise || in_fall) begin
      reset_time_counter_r  <= aresetn ? rt_r : `CST_RST_RSTTIME;
      fired_r <= 1'b0;
    end else begin
      if (tick16 && reset_time_counter_r != 8'h00) begin
        reset_time_counter_r <= reset_time_counter_r - 8'h01;
      end
      if (lr_ev) begin
        fired_r <= 1'b1;
      end
    end
  end

  // Receive sequencer: measures each high pulse and watches bit time.
  // Its events are decoded above from the same state and inputs.
  always @(posedge aclk) begin
    if (!aresetn || lr_ev || !rx_go) begin
      st_r   <= S_IDLE;
      hcnt_r <= 8'h00;
      btim_r <= 8'h00;
      if (!aresetn || lr_ev) begin
        bidx_r <= 9'h000;
        wcnt_r <= 5'h00;
      end
    end else begin
      case (st_r)
        S_IDLE: begin
          if (in_rise) begin
            st_r   <= S_HIGH;
            hcnt_r <= 8'h00;
            btim_r <= bt_r;
          end
        end
        S_HIGH: begin
          if (tick) begin
            if (hcnt_r != 8'hFF) begin
              hcnt_r <= hcnt_r + 8'h01;
            end
            btim_r <= btim_r - 8'h01;
          end
          if (in_fall) begin
            // A full word restarts the in-word bit count.
            wcnt_r <= word_ev ? 5'h00 : wcnt_r + 5'h01;
            if (is_last) begin
              bidx_r <= 9'h000;
              st_r   <= S_IDLE;
            end else begin
              bidx_r <= bidx_r + 9'h001;
              st_r   <= S_LOW;
            end
          end else if (bt_exp) begin
            st_r <= S_IDLE;
          end
        end
        S_LOW: begin
          if (in_rise) begin
            st_r   <= S_HIGH;
            hcnt_r <= 8'h00;
            btim_r <= bt_r;
          end else if (bt_exp) begin
            st_r <= S_IDLE;
          end else if (tick) begin
            btim_r <= btim_r - 8'h01;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Data bytes: software writes, received bits shift in MSB first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `CST_DATA_BYTES; i = i + 1) begin
        mem[i] <= 8'h00;
      end
    end else if (bit_ev) begin
      mem[bidx_r[8:3]] <= {mem[bidx_r[8:3]][6:0], bit_val};
    end else if (wr_ok && wk == K_DATA) begin
      mem[widx] <= w_byte_r;
    end
  end

  // Configuration registers; only the low byte lane carries them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      thr_r <= `CST_RST_THRESH;
      bt_r  <= `CST_RST_BITTIME;
      rt_r  <= `CST_RST_RSTTIME;
      grp_r <= `CST_RST_GROUP;
      div_r <= `CST_RST_CLKDIV;
      ien_r <= 4'h0;
      wien_r <= 1'b0;
    end else if (wr_ok) begin
      case (wk)
        K_THR:   thr_r  <= w_byte_r;
        K_BT:    bt_r   <= w_byte_r;
        K_RT:    rt_r   <= w_byte_r;
        K_GRP:   grp_r  <= w_byte_r[3:0];
        K_DIV:   div_r  <= w_byte_r;
        K_STAT:  ien_r  <= w_byte_r[3:0];
        K_WORD:  wien_r <= w_byte_r[`CST_WORD_IRQEN];
        default: ;
      endcase
    end
  end

  // Control and flags; hardware events are applied after software so
  // that a hardware event always wins over a software write in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_r    <= 1'b0;
      dir_r   <= 1'b0;
      bypass_r <= 1'b0;
      trig_r  <= 1'b0;
      rxen_r  <= 1'b0;
      lres_r  <= 1'b0;
      wfull_r <= 1'b0;
      gfull_r <= 1'b0;
      btout_r <= 1'b0;
      empty_r <= 1'b0;
    end else begin
      if (wr_ok && wk == K_CTRL) begin
        en_r     <= w_byte_r[`CST_CTRL_EN];
        dir_r    <= w_byte_r[`CST_CTRL_DIR];
        bypass_r <= w_byte_r[`CST_CTRL_BYPASS];
      end
      if (trig_wr && tx_on && !tx_busy) begin
        trig_r  <= 1'b1;
        empty_r <= 1'b0;
      end
      if (wr_ok && wk == K_WORD && !w_byte_r[`CST_WORD_FULL]) begin
        wfull_r <= 1'b0;
      end
      if (tx_done) begin
        empty_r <= 1'b1;
        trig_r  <= 1'b0;
      end
      if (in_rise) begin
        lres_r <= 1'b0;
      end
      if (word_ev) begin
        wfull_r <= 1'b1;
      end
      if (grp_ev) begin
        wfull_r  <= 1'b1;
        gfull_r  <= 1'b1;
        btout_r  <= 1'b0;
        bypass_r <= 1'b1;
        rxen_r   <= 1'b0;
      end
      if (to_ev) begin
        btout_r <= 1'b1;
      end
      if (last_to_ev) begin
        wfull_r <= 1'b0;
        gfull_r <= 1'b0;
      end
      if (lr_ev) begin
        lres_r   <= 1'b1;
        rxen_r   <= 1'b1;
        wfull_r  <= 1'b0;
        gfull_r  <= 1'b0;
        btout_r  <= 1'b0;
        bypass_r <= 1'b0;
      end
    end
  end

  // Output drive and interrupt lines, all registered.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sout_r <= 1'b0;
      wirq_r <= 1'b0;
      cirq_r <= 1'b0;
    end else begin
      if (tx_on) begin
        sout_r <= tx_line;
      end else begin
        sout_r <= en_r & bypass_r & ~lres_r & in_lvl;
      end
      wirq_r <= wfull_r & wien_r;
      cirq_r <= |({btout_r, lres_r, empty_r, gfull_r} & ien_r);
    end
  end
endmodule

`default_nettype wire

// [design/cst_map.vh]
// Purpose: Register offsets, field positions and reset values of the
//          cascade single-wire transceiver.
// Assumes: Byte addresses on a 32-bit AXI4-Lite slave, one word each.
// Notes:   Definitions only; included by bare name.
`ifndef CST_MAP_VH
`define CST_MAP_VH

// Register byte offsets.
`define CST_OFF_CTRL      8'h00
`define CST_OFF_STAT      8'h04
`define CST_OFF_WORD      8'h08
`define CST_OFF_THRESH    8'h0C
`define CST_OFF_BITTIME   8'h10
`define CST_OFF_RSTTIME   8'h14
`define CST_OFF_GROUP     8'h18
`define CST_OFF_CLKDIV    8'h1C
`define CST_OFF_DATA      8'h40
`define CST_DATA_BYTES    48
`define CST_DATA_BASE_IDX 6'h10

// Control register fields.
`define CST_CTRL_EN       0
`define CST_CTRL_DIR      1
`define CST_CTRL_BYPASS   2
`define CST_CTRL_TRIG     3
`define CST_CTRL_RXEN     4

// Receive word register fields.
`define CST_WORD_FULL     4
`define CST_WORD_IRQEN    0

// Reset values.
`define CST_RST_THRESH    8'h07
`define CST_RST_BITTIME   8'h20
`define CST_RST_RSTTIME   8'h80
`define CST_RST_GROUP     4'h3
`define CST_RST_CLKDIV    8'h03

// Bus answers and framing.
`define CST_RESP_OKAY     2'b00
`define CST_RESP_SLVERR   2'b10
`define CST_WORD_BITS     5'h17
`define CST_BITS_PER_N    9'h018
`define CST_TX_BITS       5'h18

`endif

// [design/cst_sync.v]
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: The pin is asynchronous to aclk.
// Notes:   A change is accepted once stages two and three agree.
`default_nettype none

module cst_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg s1_r;     // First stage, read only by the second stage.
  reg s2_r;     // Second stage.
  reg s3_r;     // Third stage.
  reg lvl_r;    // Accepted line level.

  // Accepting only agreed values keeps a single metastable sample out.
  wire agree = (s2_r == s3_r);

  assign level = lvl_r;
  assign rise  = agree & s3_r & ~lvl_r;
  assign fall  = agree & ~s3_r & lvl_r;

  // Shift chain and filtered level; idle line is taken as low.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        lvl_r <= s3_r;
      end
    end
  end
endmodule

`default_nettype wire

// [design/cst_tx.v]
// Purpose: Pulse-width encoder that shifts out one 24-bit group.
// Assumes: tick is one aclk cycle wide, once per cascade clock period.
// Notes:   A one is high thresh+2 ticks, a zero thresh-2 (at least 1).
`default_nettype none
`include "cst_map.vh"

module cst_tx (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        start,
  input  wire [7:0]  thresh,
  input  wire [23:0] data,
  output wire        line,
  output wire        busy,
  output wire        done
);
  reg [23:0] sh_r;    // Bits still to send, next one at the top.
  reg [4:0]  left_r;  // Bits remaining in the group.
  reg [8:0]  bit_time_counter_r;  // Tick position within the current bit.
  reg        act_r;   // Group in progress.
  reg        line_r;  // Registered line drive.
  reg        done_r;  // One-cycle end-of-group pulse.

  // High lengths chosen so the receiver lands clear of its dead band.
  wire [8:0] th9    = {1'b0, thresh};
  wire [8:0] hi_one = th9 + 9'h002;
  wire [8:0] hi_zer = (thresh > 8'h02) ? (th9 - 9'h002) : 9'h001;
  wire [8:0] period = {th9[7:0], 1'b0} + 9'h004;
  wire [8:0] hi_len = sh_r[23] ? hi_one : hi_zer;

  assign line = line_r;
  assign busy = act_r;
  assign done = done_r;

  // Bit-period sequencer, first byte and most significant bit first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sh_r   <= 24'h00_0000;
      left_r <= 5'h00;
      bit_time_counter_r <= 9'h000;
      act_r  <= 1'b0;
      line_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !act_r) begin
        sh_r   <= data;
        left_r <= `CST_TX_BITS;
        bit_time_counter_r <= 9'h000;
        act_r  <= 1'b1;
      end else if (act_r && tick) begin
        line_r <= (bit_time_counter_r < hi_len);
        if (bit_time_counter_r >= period - 9'h001) begin
          bit_time_counter_r <= 9'h000;
          sh_r   <= {sh_r[22:0], 1'b0};
          left_r <= left_r - 5'h01;
          if (left_r == 5'h01) begin
            act_r  <= 1'b0;
            line_r <= 1'b0;
            done_r <= 1'b1;
          end
        end else begin
          bit_time_counter_r <= bit_time_counter_r + 9'h001;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [sim/cst_props.sv]
// Purpose: Bus handshake and reset checks at the ports of cst_top.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Attached by the bind statement after the module.
`default_nettype none
module cst_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [1:0]  bresp,
  input wire logic [31:0] rdata,
  input wire logic        serial_out_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A pending write answer must block new write items.
  a_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write ready while answer pending");
  // Both items taken together answer within two edges.
  a_b_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid) else $error("write answer late");
  a_b_stable: assert property (bvalid |-> ##1 !bvalid || $stable(bresp))
    else $error("write response changed");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read ready while data pending");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  // Held read data must not move until taken.
  a_r_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed");
  // Registers are at most eight bits wide, the rest reads zero.
  a_rdata_high: assert property (rvalid |-> rdata[31:8] == 24'h0000)
    else $error("upper read bits set");
  a_rst_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !bvalid && !rvalid && !serial_out_line)
    else $error("output active after reset");
endmodule
bind cst_top cst_props i_props (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .rvalid, .rready, .arvalid, .arready, .bresp,
  .rdata, .serial_out_line);
`default_nettype wire

// [sim/cst_line_model.sv]
// Purpose: Upstream controller that drives the single-wire line.
// Assumes: The line idles low; one cascade tick per aclk.
// Notes:   The bench picks every pulse length.
`default_nettype none
module cst_line_model (
  input  wire logic aclk,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b0;
  // One bit: high for hi cycles, low for the rest of the period.
  task automatic pulse(input int hi, input int per);
    @(posedge aclk) line <= 1'b1;
    repeat (hi) @(posedge aclk);
    line <= 1'b0;
    repeat (per - hi - 1) @(posedge aclk);
  endtask
  // Steady low for n cycles; a long enough run resets the receivers.
  task automatic quiet(input int n);
    line <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask
  task automatic lvl(input logic v);
    @(posedge aclk) line <= v;
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the cascade transceiver.
// Assumes: Divider 0, so a cascade tick every aclk; threshold 7.
// Notes:   Registers are reached through AXI4-Lite tasks.
`default_nettype none
`include "cst_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int THR = 7;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        serial_in_line, serial_out_line, word_full_irq;
  logic        cascade_interrupt;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, r;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  wstrb = 4'hF;
  logic        bready = 1'b0, rready = 1'b0;
  logic [23:0] bits;
  int          n_mismatch = 0, n_tests = 0, hi;
  always #2 aclk = ~aclk;
  cst_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .serial_in_line, .serial_out_line, .word_full_irq, .cascade_interrupt);
  cst_line_model i_line (.aclk, .line(serial_in_line));
  // Write: both items offered at once, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ah = 1'b1, wh = 1'b1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ah | wh) begin
      @(negedge aclk);
      if (awready) ah = 1'b0;
      if (wready) wh = 1'b0;
      @(posedge aclk);
      awvalid <= ah;
      wvalid <= wh;
    end
    bready <= 1'b1;
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk) bready <= 1'b0;
  endtask
  // Read and compare the masked low byte.
  task automatic rc(input logic [7:0] a, input logic [7:0] e, m);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk) arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    // Accept one cycle late so the held read answer is exercised.
    @(posedge aclk) rready <= 1'b1;
    @(negedge aclk);
    r = rdata[7:0];
    rsp = rresp;
    @(posedge aclk) rready <= 1'b0;
    `CHK(r & m, e)
  endtask
  // Measure each transmitted pulse; long pulses are ones.
  task automatic tx_watch();
    int c;
    for (int i = 23; i >= 0; i--) begin
      c = 0;
      do @(negedge aclk); while (!serial_out_line);
      while (serial_out_line) begin c++; @(negedge aclk); end
      `CHK(c > THR, bits[i])
    end
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(44));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`CST_OFF_THRESH, 8'h07, 8'hFF);
    rc(`CST_OFF_GROUP, 8'h03, 8'hFF);
    // A write without the low byte lane must leave the register alone.
    wstrb <= 4'hE;
    wr(`CST_OFF_THRESH, 8'h55);
    wstrb <= 4'hF;
    rc(`CST_OFF_THRESH, 8'h07, 8'hFF);
    rc(8'h20, 8'h00, 8'hFF);
    `CHK(rsp, `CST_RESP_SLVERR)
    wr(`CST_OFF_CLKDIV, 8'h00);
    wr(`CST_OFF_RSTTIME, 8'h08);
    wr(`CST_OFF_GROUP, 8'h00);
    wr(`CST_OFF_STAT, 8'h0F);
    wr(`CST_OFF_WORD, 8'h01);
    wr(`CST_OFF_CTRL, 8'h01);
    i_line.quiet(300);
    rc(`CST_OFF_STAT, 8'h4F, 8'hFF);
    rc(`CST_OFF_CTRL, 8'h11, 8'h1F);
    // Pulse lengths kept clear of the decode edge: ones 9 to 12 cycles, zeros 2 to 6.
    for (int i = 23; i >= 0; i--) begin
      // One-cycle pulses are glitches to the input filter, so zeros
      // last at least two cycles.
      hi = $urandom % 2 ? THR + 2 + $urandom % 4 : 2 + $urandom % 5;
      bits[i] = hi > THR;
      i_line.pulse(hi, 20);
    end
    i_line.quiet(15);
    rc(`CST_OFF_DATA, bits[23:16], 8'hFF);
    rc(8'h44, bits[15:8], 8'hFF);
    rc(8'h48, bits[7:0], 8'hFF);
    rc(`CST_OFF_WORD, 8'h11, 8'hFF);
    `CHK(word_full_irq, 1'b1)
    rc(`CST_OFF_STAT, 8'h1F, 8'hFF);
    rc(`CST_OFF_CTRL, 8'h05, 8'h1F);
    `CHK(cascade_interrupt, 1'b1)
    wr(`CST_OFF_WORD, 8'h11);
    rc(`CST_OFF_WORD, 8'h11, 8'hFF);
    wr(`CST_OFF_WORD, 8'h01);
    rc(`CST_OFF_WORD, 8'h01, 8'hFF);
    wr(`CST_OFF_WORD, 8'h11);
    rc(`CST_OFF_WORD, 8'h01, 8'hFF);
    i_line.lvl(1'b1);
    repeat (8) @(negedge aclk);
    `CHK(serial_out_line, 1'b1)
    i_line.quiet(300);
    rc(`CST_OFF_WORD, 8'h01, 8'hFF);
    rc(`CST_OFF_CTRL, 8'h11, 8'h1F);
    rc(`CST_OFF_STAT, 8'h4F, 8'hFF);
    i_line.pulse(3, 60);
    rc(`CST_OFF_STAT, 8'h80, 8'hC0);
    i_line.pulse(3, 60);
    rc(`CST_OFF_DATA, {bits[22:16], 1'b0}, 8'hFF);
    i_line.quiet(300);
    rc(`CST_OFF_STAT, 8'h40, 8'hC0);
    wr(`CST_OFF_CTRL, 8'h00);
    wr(`CST_OFF_CTRL, 8'h03);
    // Two groups: the second refills and retriggers once empty is set.
    repeat (2) begin
      bits = 24'($urandom);
      wr(`CST_OFF_DATA, bits[23:16]);
      wr(8'h44, bits[15:8]);
      wr(8'h48, bits[7:0]);
      fork
        tx_watch();
        begin
          wr(`CST_OFF_CTRL, 8'h0B);
          rc(`CST_OFF_STAT, 8'h00, 8'h20);
        end
      join
      repeat (20) @(posedge aclk);
    end
    rc(`CST_OFF_STAT, 8'h20, 8'h20);
    rc(`CST_OFF_CTRL, 8'h03, 8'h0F);
    results();
  end
endmodule
`default_nettype wire
